/* rtl/pmic_io_ddr_reset_logic.sv */
// Configuration logic for pins A, B and C of the power manager.
// Assumes configuration bits and power good come from logic on mclk; pins are asynchronous.
`timescale 1ns/100ps
module pmic_io_ddr_reset_logic
  import io_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ddr_reset_mode_sel,
  input wire logic out_b_pushpull_sel,
  input wire logic core_rail_reset_en,
  input wire logic user_out_bit_a,
  input wire logic user_out_bit_b,
  input wire logic user_out_bit_c,
  input wire logic seq_pull_a_low,
  input wire logic seq_pull_c_low,
  input wire logic main_power_good,
  input wire logic buck_one_wr_en,
  input wire logic buck_two_wr_en,
  input wire logic [5:0] buck_wr_data,
  input wire logic io_pin_a_in,
  output logic io_pin_a_out,
  output logic io_pin_a_oe,
  output logic out_pin_b_out,
  output logic out_pin_b_oe,
  input wire logic io_pin_c_in,
  output logic io_pin_c_out,
  output logic io_pin_c_oe,
  output logic [5:0] buck_rail_one_vsel,
  output logic [5:0] buck_rail_two_vsel,
  output logic buck_rail_reset_pulse
);
  typedef struct packed {
    logic pg_prev;
    logic latched_b;
    logic c_prev;
    logic a_oe;
    logic b_level;
    logic b_oe;
    logic c_oe;
    logic rail_restore;
    logic pg_seen;
  } io_state_t;
  io_state_t state;
  io_state_t next_state;
  logic a_sync;
  logic c_sync;
  logic [5:0] rail_one_value;
  logic [5:0] rail_two_value;

  pin_sync u_sync_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(io_pin_a_in),
    .sync_out(a_sync)
  );

  pin_sync u_sync_c (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(io_pin_c_in),
    .sync_out(c_sync)
  );

  // Power good is assumed low at power-up and with rails off, so reset latch is low
  always_comb begin
    logic ddr_level;
    ddr_level = 1'b0;
    next_state = state;
    next_state.pg_prev = main_power_good;
    next_state.c_prev = c_sync;
    next_state.pg_seen = state.pg_seen || main_power_good;
    // Pin A
    next_state.a_oe = !ddr_reset_mode_sel && (!user_out_bit_a || seq_pull_a_low);
    // Pin B level in DDR mode
    if (main_power_good) begin
      ddr_level = a_sync;
    end else if (state.pg_prev) begin
      // Latch loads this cycle; holding avoids a stale one-cycle glitch
      ddr_level = state.b_level;
    end else begin
      ddr_level = state.latched_b;
    end
    if (ddr_reset_mode_sel && state.pg_prev && !main_power_good) begin
      next_state.latched_b = state.b_level;
    end
    if (ddr_reset_mode_sel) begin
      next_state.b_level = ddr_level;
      next_state.b_oe = out_b_pushpull_sel || !ddr_level;
    end else if (out_b_pushpull_sel) begin
      next_state.b_level = user_out_bit_b;
      next_state.b_oe = 1'b1;
    end else begin
      next_state.b_level = user_out_bit_b;
      next_state.b_oe = !user_out_bit_b;
    end
    // Pin C
    next_state.c_oe = !core_rail_reset_en && (!user_out_bit_c || seq_pull_c_low);
    next_state.rail_restore = core_rail_reset_en && state.c_prev && !c_sync;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{pg_prev: 1'b0, latched_b: RESET_LEVEL_LOW, c_prev: 1'b1, a_oe: 1'b0,
                 b_level: RESET_LEVEL_LOW, b_oe: 1'b0, c_oe: 1'b0, rail_restore: 1'b0,
                 pg_seen: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  // Restored values only; slew ramp stays with the rail controller, no power cycle
  rail_voltage_reg u_rail_one (
    .mclk(mclk),
    .rst_n(rst_n),
    .default_value(BUCK_ONE_DEFAULT),
    .wr_en(buck_one_wr_en),
    .wr_data(buck_wr_data),
    .restore(state.rail_restore),
    .value(rail_one_value)
  );

  rail_voltage_reg u_rail_two (
    .mclk(mclk),
    .rst_n(rst_n),
    .default_value(BUCK_TWO_DEFAULT),
    .wr_en(buck_two_wr_en),
    .wr_data(buck_wr_data),
    .restore(state.rail_restore),
    .value(rail_two_value)
  );

  assign io_pin_a_out = 1'b0;
  assign io_pin_a_oe = state.a_oe;
  assign out_pin_b_out = state.b_level;
  assign out_pin_b_oe = state.b_oe;
  assign io_pin_c_out = 1'b0;
  assign io_pin_c_oe = state.c_oe;
  assign buck_rail_one_vsel = rail_one_value;
  assign buck_rail_two_vsel = rail_two_value;
  assign buck_rail_reset_pulse = state.rail_restore;

  property p_pin_c_quiet;
    @(posedge mclk) disable iff (!rst_n)
    core_rail_reset_en |=> !io_pin_c_oe;
  endproperty
  a_pin_c_quiet: assert property (p_pin_c_quiet) else $error("Pin C driven in reset mode");

  property p_rail_restore;
    @(posedge mclk) disable iff (!rst_n)
    state.rail_restore |=> (buck_rail_one_vsel == BUCK_ONE_DEFAULT)
      && (buck_rail_two_vsel == BUCK_TWO_DEFAULT);
  endproperty
  a_rail_restore: assert property (p_rail_restore) else $error("Rails not restored");

  property p_latch_hold;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && !main_power_good)[*3]
      |-> $stable(out_pin_b_out);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Pin B changed while latched");

  property p_pass_through;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && main_power_good) |=> (out_pin_b_out == $past(a_sync));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("Pin B not following pin A");

  property p_b_pushpull;
    @(posedge mclk) disable iff (!rst_n)
    out_b_pushpull_sel |=> out_pin_b_oe;
  endproperty
  a_b_pushpull: assert property (p_b_pushpull) else $error("Push-pull pin B not driven");

  property p_b_opendrain;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && !out_b_pushpull_sel) |=> (out_pin_b_oe == !out_pin_b_out);
  endproperty
  a_b_opendrain: assert property (p_b_opendrain) else $error("Open-drain pin B drives high");

  property p_pin_a;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && !user_out_bit_a) |=> io_pin_a_oe;
  endproperty
  a_pin_a: assert property (p_pin_a) else $error("Pin A not pulled low");

  property p_pin_c;
    @(posedge mclk) disable iff (!rst_n)
    (!core_rail_reset_en && user_out_bit_c && !seq_pull_c_low) |=> !io_pin_c_oe;
  endproperty
  a_pin_c: assert property (p_pin_c) else $error("Pin C not released");

  property p_c_edge;
    @(posedge mclk) disable iff (!rst_n)
    (core_rail_reset_en && c_sync) ##1 (core_rail_reset_en && !c_sync) |=> buck_rail_reset_pulse;
  endproperty
  a_c_edge: assert property (p_c_edge) else $error("Pin C fall missed");

  property p_pin_a_release;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && user_out_bit_a && !seq_pull_a_low) |=> !io_pin_a_oe;
  endproperty
  a_pin_a_release: assert property (p_pin_a_release) else $error("Pin A not released");

  property p_pin_a_seq;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && seq_pull_a_low) |=> io_pin_a_oe;
  endproperty
  a_pin_a_seq: assert property (p_pin_a_seq) else $error("Pin A sequencer pull lost");

  property p_pin_a_input;
    @(posedge mclk) disable iff (!rst_n)
    ddr_reset_mode_sel |=> !io_pin_a_oe;
  endproperty
  a_pin_a_input: assert property (p_pin_a_input) else $error("Pin A driven in DDR mode");

  property p_pin_c_pull;
    @(posedge mclk) disable iff (!rst_n)
    (!core_rail_reset_en && !user_out_bit_c) |=> io_pin_c_oe;
  endproperty
  a_pin_c_pull: assert property (p_pin_c_pull) else $error("Pin C not pulled low");

  property p_pin_c_seq;
    @(posedge mclk) disable iff (!rst_n)
    (!core_rail_reset_en && seq_pull_c_low) |=> io_pin_c_oe;
  endproperty
  a_pin_c_seq: assert property (p_pin_c_seq) else $error("Pin C sequencer pull lost");

  property p_b_user_low;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && !user_out_bit_b) |=> (out_pin_b_oe && !out_pin_b_out);
  endproperty
  a_b_user_low: assert property (p_b_user_low) else $error("Pin B not driven low");

  property p_b_user_level;
    @(posedge mclk) disable iff (!rst_n)
    !ddr_reset_mode_sel |=> (out_pin_b_out == $past(user_out_bit_b));
  endproperty
  a_b_user_level: assert property (p_b_user_level) else $error("Pin B not from user bit");

  property p_b_od_release;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && !out_b_pushpull_sel && user_out_bit_b) |=> !out_pin_b_oe;
  endproperty
  a_b_od_release: assert property (p_b_od_release) else $error("Pin B not released");

  property p_b_pp_high;
    @(posedge mclk) disable iff (!rst_n)
    (!ddr_reset_mode_sel && out_b_pushpull_sel && user_out_bit_b)
      |=> (out_pin_b_oe && out_pin_b_out);
  endproperty
  a_b_pp_high: assert property (p_b_pp_high) else $error("Pin B not driven high");

  property p_b_ddr_od;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && !out_b_pushpull_sel) |=> (out_pin_b_oe == !out_pin_b_out);
  endproperty
  a_b_ddr_od: assert property (p_b_ddr_od) else $error("DDR pin B drives high");

  property p_b_ddr_output;
    @(posedge mclk) disable iff (!rst_n)
    ddr_reset_mode_sel |=> (out_pin_b_oe || out_pin_b_out);
  endproperty
  a_b_ddr_output: assert property (p_b_ddr_output) else $error("Pin B not an output");

  property p_b_follow_low;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && main_power_good && !a_sync)
      |=> (out_pin_b_oe && !out_pin_b_out);
  endproperty
  a_b_follow_low: assert property (p_b_follow_low) else $error("Pin B not low with pin A");

  property p_b_od_never_high;
    @(posedge mclk) disable iff (!rst_n)
    !out_b_pushpull_sel |=> !(out_pin_b_oe && out_pin_b_out);
  endproperty
  a_b_od_never_high: assert property (p_b_od_never_high) else $error("Pin B pushed high");

  property p_latch_capture;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && $past(main_power_good) && !main_power_good)
      |=> $stable(out_pin_b_out);
  endproperty
  a_latch_capture: assert property (p_latch_capture) else $error("Pin B glitched at fall");

  property p_power_up_low;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && !main_power_good && !state.pg_seen) |=> !out_pin_b_out;
  endproperty
  a_power_up_low: assert property (p_power_up_low) else $error("Pin B high after reset");

  property p_latch_source;
    @(posedge mclk) disable iff (!rst_n)
    (ddr_reset_mode_sel && !main_power_good && !state.pg_prev)
      |=> (out_pin_b_out == $past(state.latched_b));
  endproperty
  a_latch_source: assert property (p_latch_source) else $error("Pin B not from latch");

  property p_no_pulse_off;
    @(posedge mclk) disable iff (!rst_n)
    !core_rail_reset_en |=> !buck_rail_reset_pulse;
  endproperty
  a_no_pulse_off: assert property (p_no_pulse_off) else $error("Restore outside reset mode");

  property p_pulse_one_cycle;
    @(posedge mclk) disable iff (!rst_n)
    buck_rail_reset_pulse |=> !buck_rail_reset_pulse;
  endproperty
  a_pulse_one_cycle: assert property (p_pulse_one_cycle) else $error("Restore pulse too long");

  property p_pulse_needs_fall;
    @(posedge mclk) disable iff (!rst_n)
    buck_rail_reset_pulse |-> ($past(c_sync, 2) && !$past(c_sync));
  endproperty
  a_pulse_needs_fall: assert property (p_pulse_needs_fall) else $error("Restore without fall");

  property p_rail_one_write;
    @(posedge mclk) disable iff (!rst_n)
    (buck_one_wr_en && !buck_rail_reset_pulse)
      |=> (buck_rail_one_vsel == $past(buck_wr_data));
  endproperty
  a_rail_one_write: assert property (p_rail_one_write) else $error("Rail one write lost");

  property p_rail_two_write;
    @(posedge mclk) disable iff (!rst_n)
    (buck_two_wr_en && !buck_rail_reset_pulse)
      |=> (buck_rail_two_vsel == $past(buck_wr_data));
  endproperty
  a_rail_two_write: assert property (p_rail_two_write) else $error("Rail two write lost");

  property p_rail_one_hold;
    @(posedge mclk) disable iff (!rst_n)
    (!buck_one_wr_en && !buck_rail_reset_pulse) |=> $stable(buck_rail_one_vsel);
  endproperty
  a_rail_one_hold: assert property (p_rail_one_hold) else $error("Rail one changed alone");

  property p_rail_two_hold;
    @(posedge mclk) disable iff (!rst_n)
    (!buck_two_wr_en && !buck_rail_reset_pulse) |=> $stable(buck_rail_two_vsel);
  endproperty
  a_rail_two_hold: assert property (p_rail_two_hold) else $error("Rail two changed alone");
endmodule

/* common/io_cfg_pkg.sv */
// Constants for the pin configuration logic of the power manager.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
// Summary of operation
// - With DDR reset mode off, pin A is open-drain: user bit 0 pulls low, 1 releases; sequencer may pull too.
// - With DDR reset mode on and power good high, pin A is an input and its level is copied to pin B.
// - With DDR reset mode on, pin B's level is latched at the falling edge of power good and held while low.
// - With DDR reset mode on and power good low, pin B is low after power-on reset until a value is latched.
// - With DDR reset mode off and push-pull select 0, pin B is open-drain from its user bit.
// - With DDR reset mode off and push-pull select 1, pin B is push-pull from its user bit.
// - With DDR reset mode on, pin B's level comes from pin A and power good; buffer select still applies.
// - With DDR reset mode on, pin B is an output without further setting.
// - With core rail reset off, pin C is open-drain: user bit 0 pulls low, 1 releases; sequencer may pull too.
// - With core rail reset on, pin C is an active-low reset input driven by the host, never by the device.
// - Each falling edge on pin C in reset mode restores only the two buck rail voltage registers.
// - After that reset the two rails ramp to defaults at the programmed slew, not power cycled.
// - Main power good is low at power-up and low whenever all rails are disabled.
package io_cfg_pkg;
  localparam logic [5:0] BUCK_ONE_DEFAULT = 6'h00;
  localparam logic [5:0] BUCK_TWO_DEFAULT = 6'h00;
  localparam logic RESET_LEVEL_LOW = 1'b0;
endpackage

/* rtl/pin_sync.sv */
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is unrelated to mclk.
`timescale 1ns/100ps
module pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state.meta = async_in;
    next_state.sync = state.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{meta: 1'b1, sync: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.sync;
endmodule

/* rtl/rail_voltage_reg.sv */
// Voltage setting register of one buck rail with a level-sensitive restore.
// Assumes restore is a one-cycle pulse on mclk.
`timescale 1ns/100ps
module rail_voltage_reg (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [5:0] default_value,
  input wire logic wr_en,
  input wire logic [5:0] wr_data,
  input wire logic restore,
  output logic [5:0] value
);
  typedef struct packed {
    logic [5:0] value;
  } rail_state_t;
  rail_state_t state;
  rail_state_t next_state;

  always_comb begin
    next_state = state;
    if (restore) begin
      next_state.value = default_value;
    end else if (wr_en) begin
      next_state.value = wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{value: 6'h00};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;
endmodule

/* tb/host_model.sv */
// Host side of pins A and C: open-drain pulls onto pulled-up wires.
// Assumes device enables mean pull low; released wires read high.
`timescale 1ns/100ps
module host_model (
  input wire logic a_drive_low,
  input wire logic c_drive_low,
  input wire logic io_pin_a_oe,
  input wire logic io_pin_c_oe,
  output logic io_pin_a_in,
  output logic io_pin_c_in
);
  // Wired-AND with pull-up, so a released wire never holds a stale level
  assign io_pin_a_in = !(a_drive_low | io_pin_a_oe);
  assign io_pin_c_in = !(c_drive_low | io_pin_c_oe);
endmodule

/* tb/test_pmic_io_ddr_reset_logic.sv */
// Self-checking bench for the pin configuration logic.
// Assumes one 125 MHz clock; host model closes the pin A and C wires.
`timescale 1ns/100ps
module test_pmic_io_ddr_reset_logic;
  import io_cfg_pkg::*;
  logic mclk = 0, rst_n = 0, mode = 0, pp = 0, rst_en = 0, ua = 1, ub = 1, uc = 1;
  logic sqa = 0, sqc = 0, pg = 0, w1 = 0, w2 = 0, ha = 0, hc = 0;
  logic [5:0] wd = 6'h00, d1, d2, v1, v2;
  logic pa, pc, a_out, a_oe, b_out, b_oe, c_out, c_oe, pulse, b_wire;
  int err_count = 0, num_checks = 0, pulses = 0, p0;
  assign b_wire = b_oe ? b_out : 1'bz;
  always #4 mclk = ~mclk;
  always @(posedge mclk) if (pulse === 1'b1) pulses <= pulses + 1;
  pmic_io_ddr_reset_logic dut_u (.mclk(mclk), .rst_n(rst_n), .ddr_reset_mode_sel(mode),
    .out_b_pushpull_sel(pp), .core_rail_reset_en(rst_en), .user_out_bit_a(ua),
    .user_out_bit_b(ub), .user_out_bit_c(uc), .seq_pull_a_low(sqa), .seq_pull_c_low(sqc),
    .main_power_good(pg), .buck_one_wr_en(w1), .buck_two_wr_en(w2), .buck_wr_data(wd),
    .io_pin_a_in(pa), .io_pin_a_out(a_out), .io_pin_a_oe(a_oe), .out_pin_b_out(b_out),
    .out_pin_b_oe(b_oe), .io_pin_c_in(pc), .io_pin_c_out(c_out), .io_pin_c_oe(c_oe),
    .buck_rail_one_vsel(v1), .buck_rail_two_vsel(v2), .buck_rail_reset_pulse(pulse));
  host_model host_u (.a_drive_low(ha), .c_drive_low(hc), .io_pin_a_oe(a_oe),
    .io_pin_c_oe(c_oe), .io_pin_a_in(pa), .io_pin_c_in(pc));
  task chk(input logic [5:0] got, input logic [5:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Wire level of pin B: open drain only ever pulls low
  function logic exp_b(input logic p, input logic l);
    return p ? l : (l ? 1'bz : 1'b0);
  endfunction
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2d00));
    cyc(9);
    #1 chk({2'b00, a_oe, b_oe, c_oe, pulse}, 6'h00);
    chk(v1, 6'h00);
    cyc(1);
    rst_n <= 1;
    repeat (40) begin
      @(posedge mclk);
      {ua, ub, uc, pp, sqa, sqc} <= 6'($urandom);
      cyc(2);
      #1 chk_bit(a_oe, !ua | sqa);
      chk_bit(b_wire, exp_b(pp, ub));
      chk_bit(c_oe, !uc | sqc);
      chk_bit(a_out | c_out, 1'b0);
    end
    @(posedge mclk);
    {sqa, sqc, mode, pp, ub, ua} <= 6'b001111;
    cyc(4);
    #1 chk_bit(a_oe, 1'b0);
    chk_bit(b_wire, 1'b0);
    @(posedge mclk);
    pg <= 1;
    repeat (12) begin
      @(posedge mclk);
      {ha, pp, ub} <= 3'($urandom);
      cyc(5);
      #1 chk_bit(b_wire, exp_b(pp, !ha));
    end
    @(posedge mclk);
    {ha, pp} <= 2'b01;
    cyc(5);
    pg <= 0;
    cyc(2);
    ha <= 1;
    cyc(6);
    #1 chk_bit(b_wire, 1'b1);
    @(posedge mclk);
    pg <= 1;
    cyc(5);
    #1 chk_bit(b_wire, 1'b0);
    @(posedge mclk);
    {mode, ha, uc} <= 3'b001;
    d1 = 6'($urandom) | 6'h01;
    d2 = 6'($urandom) | 6'h02;
    w1 <= 1;
    wd <= d1;
    cyc(1);
    w1 <= 0;
    w2 <= 1;
    wd <= d2;
    cyc(1);
    w2 <= 0;
    hc <= 1;
    cyc(8);
    #1 chk(v1, d1);
    chk(v2, d2);
    @(posedge mclk);
    hc <= 0;
    rst_en <= 1;
    uc <= 0;
    cyc(6);
    #1 chk_bit(c_oe, 1'b0);
    chk_bit(c_out, 1'b0);
    p0 = pulses;
    @(posedge mclk);
    hc <= 1;
    cyc(10);
    #1 chk(v1, BUCK_ONE_DEFAULT);
    chk(v2, BUCK_TWO_DEFAULT);
    @(posedge mclk);
    hc <= 0;
    cyc(8);
    #1 chk(6'(pulses - p0), 6'h01);
    print_verdict;
  end
  // Whole sequence needs a few microseconds
  initial begin
    #20us;
    err_count++;
    print_verdict;
  end
endmodule
